// file: bench/boot_ctrl_properties.sv
// checker: port-level timing of the reset and boot block
// assumes BOOT_CYCLES is 20 and that it is bound to the top module
`timescale 1ns/1ps
module boot_ctrl_checker (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // watched inputs
    input wire logic i_master_reset_n,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    // watched outputs
    input wire logic [7:0] o_pix_data,
    input wire logic [1:0] o_pix_lsb,
    input wire logic o_line_active_short,
    input wire logic o_frame_active,
    input wire logic o_video_oe,
    input wire logic o_twowire_data_pin_oe,
    input wire logic o_boot_done,
    input wire logic o_in_reset
);
    // ==========================================================
    // properties
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence soft_set_s;
        i_reg_wr && i_reg_addr == 16'h001A && i_reg_wdata[0];
    endsequence
    sequence boot_wait_s;
        !o_boot_done [*8];
    endsequence
    a_soft_reset_acts: assert property (soft_set_s |-> ##2 o_in_reset && !o_video_oe)
        else $error("soft reset did not reach reset state");
    a_pin_reset_acts: assert property ($fell(i_master_reset_n) |-> ##[1:6] o_in_reset)
        else $error("pin reset did not reach reset state");
    a_reset_video_off: assert property (o_in_reset |-> !o_video_oe && !o_boot_done)
        else $error("video pads driven in reset");
    a_reset_twowire_in: assert property (o_in_reset |-> !o_twowire_data_pin_oe)
        else $error("data pad driven in reset");
    a_boot_pads_off: assert property (!o_boot_done |-> !o_video_oe)
        else $error("video pads driven during boot");
    a_boot_min_time: assert property ($fell(o_in_reset) |-> boot_wait_s)
        else $error("boot ended too early");
    a_boot_max_time: assert property ($fell(o_in_reset) |->
        ##[1:40] (o_boot_done || o_in_reset))
        else $error("boot did not end in time");
    a_line_in_frame: assert property (o_line_active_short |-> o_frame_active)
        else $error("line active outside frame");
    a_blank_zero: assert property (!o_line_active_short |->
        o_pix_data == 8'h00 && o_pix_lsb == 2'h0)
        else $error("nonzero data in blanking");
endmodule // boot_ctrl_checker

bind sensor_reset_boot_control boot_ctrl_checker i_boot_ctrl_checker (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_master_reset_n(i_master_reset_n),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_pix_data(o_pix_data), .o_pix_lsb(o_pix_lsb), .o_line_active_short(o_line_active_short),
    .o_frame_active(o_frame_active), .o_video_oe(o_video_oe),
    .o_twowire_data_pin_oe(o_twowire_data_pin_oe), .o_boot_done(o_boot_done),
    .o_in_reset(o_in_reset));

// file: bench/host_side_model.sv
// host model: master reset pin and decoded register writes
// assumes the system clock runs around every reset pulse
`timescale 1ns/1ps
module host_side_model (
    // clock and status
    input wire logic i_sys_clk,
    input wire logic i_boot_done,
    // toward the block
    output logic o_master_reset_n,
    output logic o_reg_wr,
    output logic [15:0] o_reg_addr,
    output logic [15:0] o_reg_wdata
);
    initial begin
        o_master_reset_n = 1'b1;
        o_reg_wr = 1'b0;
        o_reg_addr = 16'h0000;
        o_reg_wdata = 16'h0000;
    end
    // ==========================================================
    // tasks
    task automatic pin_reset(input int cycles);
        @(posedge i_sys_clk);
        o_master_reset_n <= 1'b0;
        repeat ((cycles < 50) ? 50 : cycles) @(posedge i_sys_clk);
        o_master_reset_n <= 1'b1;
    endtask
    task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
        @(posedge i_sys_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= addr;
        o_reg_wdata <= data;
        @(posedge i_sys_clk);
        o_reg_wr <= 1'b0;
        // released lines must not keep showing the last value
        o_reg_addr <= ~addr;
        o_reg_wdata <= ~data;
    endtask
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(posedge i_sys_clk);
            ok = (i_boot_done === 1'b1);
        end
    endtask
endmodule // host_side_model

// file: bench/tb_sensor_reset_boot_control.sv
// testbench: reset sources, boot timing, pad states and frame timing
// assumes BOOT_CYCLES shortened to 20 and default frame geometry
`timescale 1ns/1ps
module tb_sensor_reset_boot_control;
    logic sys_clk, rst_n, master_reset_n, boot_config, out_enable_n, reg_wr;
    logic standby_req, tw_drive, pclk, line_act, frame_act, video_oe, tw_oe, boot_done, in_reset;
    logic [15:0] reg_addr, reg_wdata;
    logic [9:0] pixel;
    logic [7:0] pix_data;
    logic [1:0] pix_lsb;
    int bad_count = 0;
    int cmp_count = 0;
    localparam int LINE_CLKS = (boot_ctrl_pkg::ACT_W + boot_ctrl_pkg::HBLANK) * 2;
    sensor_reset_boot_control #(.BOOT_CYCLES(20)) i_sensor_reset_boot_control (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_master_reset_n(master_reset_n),
        .i_boot_config(boot_config), .i_out_enable_n(out_enable_n), .i_reg_wr(reg_wr),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_standby_req(standby_req),
        .i_pixel(pixel), .i_twowire_data_drive(tw_drive), .o_pix_data(pix_data),
        .o_pix_lsb(pix_lsb), .o_pixel_clock_out(pclk), .o_line_active_short(line_act),
        .o_frame_active(frame_act), .o_video_oe(video_oe), .o_twowire_data_pin_oe(tw_oe),
        .o_boot_done(boot_done), .o_in_reset(in_reset));
    host_side_model i_host_side_model (.i_sys_clk(sys_clk), .i_boot_done(boot_done),
        .o_master_reset_n(master_reset_n), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata));
    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic boot_ok(input logic oe);
        logic ok;
        i_host_side_model.wait_ready(ok);
        chk(ok, 1'b1);
        repeat (6) @(posedge sys_clk);
        chk(video_oe, oe);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_power_on;
        repeat (10) @(posedge sys_clk);
        chk(video_oe, 1'b0);
        chk(boot_done, 1'b0);
        boot_ok(1'b1);
    endtask
    task automatic t_frame;
        int act = 0;
        int blank = 0;
        int bad_pix = 0;
        int hi = 0;
        int len = 0;
        int n = 0;
        // the bench arrives in mid-frame, so first wait for vertical blanking
        while (frame_act !== 1'b0 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        while (frame_act !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        do begin
            len++;
            if (pclk === 1'b1) hi++;
            if (line_act === 1'b1) begin
                act++;
                if (pix_data !== pixel[9:2] || pix_lsb !== pixel[1:0]) bad_pix++;
            end else if (pix_data !== 8'h00 || pix_lsb !== 2'h0) begin
                blank++;
            end
            @(posedge sys_clk);
            n++;
        end while (frame_act === 1'b1 && n < 2000);
        chk(16'(act), 16'(boot_ctrl_pkg::ACT_W * boot_ctrl_pkg::ACT_H * 2));
        chk(16'(len), 16'(LINE_CLKS * boot_ctrl_pkg::ACT_H));
        chk(16'(hi), 16'(LINE_CLKS * boot_ctrl_pkg::ACT_H / 2));
        chk(16'(bad_pix), 16'h0000);
        chk(16'(blank), 16'h0000);
    endtask
    task automatic t_soft_reset;
        i_host_side_model.reg_write(16'h001B, 16'h0001);
        repeat (4) @(posedge sys_clk);
        chk(in_reset, 1'b0);
        i_host_side_model.reg_write(16'h001A, 16'h0001);
        repeat (4) @(posedge sys_clk);
        chk(in_reset, 1'b1);
        chk(tw_oe, 1'b0);
        chk(video_oe, 1'b0);
        i_host_side_model.reg_write(16'h001A, 16'h0000);
        repeat (5) @(posedge sys_clk);
        chk(boot_done, 1'b0);
        boot_ok(1'b1);
    endtask
    task automatic t_pin_reset;
        fork
            i_host_side_model.pin_reset(50);
            begin
                repeat (20) @(posedge sys_clk);
                chk(in_reset, 1'b1);
                chk(video_oe, 1'b0);
                chk(tw_oe, 1'b0);
            end
        join
        boot_ok(1'b1);
        // the pad follows the serial slave once out of reset
        tw_drive <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(tw_oe, 1'b0);
        tw_drive <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(tw_oe, 1'b1);
    endtask
    task automatic t_standby;
        boot_config <= 1'b0;
        standby_req <= 1'b1;
        i_host_side_model.pin_reset(50);
        boot_ok(1'b0);
        chk(pclk, 1'b0);
        standby_req <= 1'b0;
        boot_config <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(video_oe, 1'b1);
    endtask
    task automatic t_oe_high;
        out_enable_n <= 1'b1;
        i_host_side_model.pin_reset(50);
        boot_ok(1'b0);
        out_enable_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk(video_oe, 1'b1);
    endtask
    // ==========================================================
    // run
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #1_000_000;
        bad_count++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        boot_config = 1'b1;
        out_enable_n = 1'b0;
        standby_req = 1'b0;
        pixel = 10'h3FF;
        tw_drive = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_power_on();
        t_frame();
        t_soft_reset();
        t_pin_reset();
        t_standby();
        t_oe_high();
        end_sim();
    end
endmodule // tb_sensor_reset_boot_control

// file: logic/boot_ctrl_pkg.sv
// package: constants for the sensor reset and boot control block
// assumes a single system clock at 10 MHz and register writes decoded from the two-wire bus
package boot_ctrl_pkg;
    // system clock
    localparam int unsigned CLK_HZ = 10_000_000;
    // internal boot time, in microseconds
    localparam int unsigned BOOT_TIME_US = 44_500;
    // boot cycles at the system clock; a typical figure, so the host still polls
    localparam int unsigned BOOT_CYCLES = (BOOT_TIME_US / 1000) * (CLK_HZ / 1000)
        + ((BOOT_TIME_US % 1000) * (CLK_HZ / 1000)) / 1000;
    // pixel output is held for two system clock periods (one pixel clock period) per pixel
    localparam int unsigned PIX_PER_DIV = 2;
    // system control register address and soft reset bit
    localparam logic [15:0] SYSTEM_CONTROL_REG_ADDR = 16'h001A;
    localparam int unsigned SOFT_RESET_BIT = 0;
    // default frame geometry
    localparam int unsigned ACT_W = 16;
    localparam int unsigned ACT_H = 8;
    localparam int unsigned HBLANK = 8;
    localparam int unsigned VBLANK = 4;
    // reset values
    localparam logic [7:0] PIX_RST = 8'h00;
    localparam logic [1:0] LSB_RST = 2'h0;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_BOOT = 2'b01,
        ST_STANDBY = 2'b10,
        ST_STREAM = 2'b11
    } boot_state_t;
endpackage

// file: logic/sensor_reset_boot_control.sv
// sensor_reset_boot_control: reset merge, boot timer, pad tristate and frame timing
// assumes the serial register decoder upstream hands over writes as strobe/addr/data
// How it works
// [R1] an internal power-on reset fires with no external pin activity
// [R2] pin reset, soft reset bit and power-on reset all reset the block
// [R3] soft reset acts exactly like the hard reset pin
// [R4] reset is held while the master reset pin is low
// [R5] video pads are high impedance in reset and standby
// [R6] two-wire data pad only receives while in reset
// [R7] with output enable pin high, pads stay high impedance through boot
// [R8] host holds reset 50 clocks, clock runs 10 clocks after it
// [R9] host runs the clock 10 cycles before releasing reset
// [R10] after reset release the device boots for 44.5 ms
// [R11] host polls the command register to learn boot is done
// [R12] host waits out the boot time before its first serial command
// [R13] frames scan progressively with programmable blanking around the image
// [R14] line active is high only on valid pixels of a row
// [R15] floating reset and boot config pins read as high
// [R16] boot config high streams after boot, low waits in standby; the code leaves standby as soon as i_standby_req is low
// [R17] soft reset is bit 0 of the system control register, set then cleared
// [R18] pixel data is zero while line active is low
`timescale 1ns/1ps
module sensor_reset_boot_control #(
    parameter int unsigned BOOT_CYCLES = boot_ctrl_pkg::BOOT_CYCLES,
    parameter int unsigned ACT_W = boot_ctrl_pkg::ACT_W,
    parameter int unsigned ACT_H = boot_ctrl_pkg::ACT_H,
    parameter int unsigned HBLANK = boot_ctrl_pkg::HBLANK,
    parameter int unsigned VBLANK = boot_ctrl_pkg::VBLANK
) (
    // clock and power-on reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // pins (pull-ups outside resolve floating to high)
    input wire logic i_master_reset_n,
    input wire logic i_boot_config,
    input wire logic i_out_enable_n,
    // decoded two-wire register writes
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    // standby request from the command path
    input wire logic i_standby_req,
    // pixel source
    input wire logic [9:0] i_pixel,
    // two-wire data pad driver enable from the serial slave
    input wire logic i_twowire_data_drive,
    // video outputs and their enables
    output logic [7:0] o_pix_data,
    output logic [1:0] o_pix_lsb,
    output logic o_pixel_clock_out,
    output logic o_line_active_short,
    output logic o_frame_active,
    output logic o_video_oe,
    // two-wire data pad
    output logic o_twowire_data_pin_oe,
    // status
    output logic o_boot_done,
    output logic o_in_reset
);
    localparam int unsigned LINE_LEN = ACT_W + HBLANK;
    localparam int unsigned FRAME_LEN = ACT_H + VBLANK;
    localparam int unsigned BCW = $clog2(BOOT_CYCLES + 1);

    // =====================================
    // pin synchronisers, three flops, change taken when last two agree
    logic [2:0] rst_sync_q, rst_sync_d;
    logic [2:0] cfg_sync_q, cfg_sync_d;
    logic [2:0] oe_sync_q, oe_sync_d;
    logic pin_rst_n_q, pin_rst_n_d;
    logic cfg_q, cfg_d;
    logic oe_n_q, oe_n_d;

    always_comb begin
        rst_sync_d = {rst_sync_q[1:0], i_master_reset_n};
        cfg_sync_d = {cfg_sync_q[1:0], i_boot_config};
        oe_sync_d = {oe_sync_q[1:0], i_out_enable_n};
        pin_rst_n_d = (rst_sync_q[2] == rst_sync_q[1]) ? rst_sync_q[1] : pin_rst_n_q;
        cfg_d = (cfg_sync_q[2] == cfg_sync_q[1]) ? cfg_sync_q[1] : cfg_q;
        oe_n_d = (oe_sync_q[2] == oe_sync_q[1]) ? oe_sync_q[1] : oe_n_q;
    end

    // floating pins read high, so reset to high [R15]
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 3'h7;
            cfg_sync_q <= 3'h7;
            oe_sync_q <= 3'h7;
            pin_rst_n_q <= 1'b1;
            cfg_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else begin
            rst_sync_q <= rst_sync_d;
            cfg_sync_q <= cfg_sync_d;
            oe_sync_q <= oe_sync_d;
            pin_rst_n_q <= pin_rst_n_d;
            cfg_q <= cfg_d;
            oe_n_q <= oe_n_d;
        end
    end

    // =====================================
    // soft reset bit and merged reset
    logic soft_rst_q, soft_rst_d;
    logic any_rst;

    always_comb begin
        soft_rst_d = soft_rst_q;
        if (i_reg_wr && i_reg_addr == boot_ctrl_pkg::SYSTEM_CONTROL_REG_ADDR) begin
            soft_rst_d = i_reg_wdata[boot_ctrl_pkg::SOFT_RESET_BIT]; // [R17]
        end
    end

    // the soft bit itself survives the reset it causes, else it could never be cleared
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= soft_rst_d;
        end
    end

    // power-on reset comes in on i_rst_n and clears everything [R1]
    assign any_rst = !pin_rst_n_q || soft_rst_q; // [R2] [R3] [R4]

    // =====================================
    // boot sequencer
    boot_ctrl_pkg::boot_state_t state_q, state_d;
    logic [BCW-1:0] boot_cnt_q, boot_cnt_d;

    always_comb begin
        state_d = state_q;
        boot_cnt_d = boot_cnt_q;
        if (any_rst) begin
            state_d = boot_ctrl_pkg::ST_RESET; // [R3] [R4]
            boot_cnt_d = '0;
        end else begin
            unique case (state_q)
                boot_ctrl_pkg::ST_RESET: begin
                    state_d = boot_ctrl_pkg::ST_BOOT;
                    boot_cnt_d = '0;
                end
                boot_ctrl_pkg::ST_BOOT: begin
                    boot_cnt_d = boot_cnt_q + BCW'(1);
                    if (boot_cnt_q == BCW'(BOOT_CYCLES - 1)) begin // [R10]
                        state_d = cfg_q ? boot_ctrl_pkg::ST_STREAM
                                        : boot_ctrl_pkg::ST_STANDBY; // [R16]
                    end
                end
                boot_ctrl_pkg::ST_STANDBY: begin
                    if (!i_standby_req) begin
                        state_d = boot_ctrl_pkg::ST_STREAM;
                    end
                end
                boot_ctrl_pkg::ST_STREAM: begin
                    if (i_standby_req) begin
                        state_d = boot_ctrl_pkg::ST_STANDBY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= boot_ctrl_pkg::ST_RESET; // [R1]
            boot_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            boot_cnt_q <= boot_cnt_d;
        end
    end

    // =====================================
    // frame timing: pixel clock divider, column and row counters
    localparam int unsigned CW = $clog2(LINE_LEN + 1);
    localparam int unsigned RW = $clog2(FRAME_LEN + 1);
    logic streaming;
    logic pclk_q, pclk_d;
    logic [CW-1:0] col_q, col_d;
    logic [RW-1:0] row_q, row_d;
    logic line_act;
    logic [7:0] pix_d;
    logic [1:0] lsb_d;
    logic video_oe_d;

    // gated by the merged reset so the pads drop one cycle after the reset lands, together with o_in_reset, not a cycle later
    assign streaming = (state_q == boot_ctrl_pkg::ST_STREAM) && !any_rst; // [R5]
    assign line_act = streaming && col_q < CW'(ACT_W) && row_q < RW'(ACT_H); // [R14]

    always_comb begin
        pclk_d = streaming ? !pclk_q : 1'b0;
        col_d = col_q;
        row_d = row_q;
        if (!streaming) begin
            col_d = '0;
            row_d = '0;
        end else if (pclk_q) begin
            // one pixel per two clock periods; blanking wraps the image [R13]
            if (col_q == CW'(LINE_LEN - 1)) begin
                col_d = '0;
                row_d = (row_q == RW'(FRAME_LEN - 1)) ? '0 : row_q + RW'(1);
            end else begin
                col_d = col_q + CW'(1);
            end
        end
        pix_d = line_act ? i_pixel[9:2] : boot_ctrl_pkg::PIX_RST; // [R18]
        lsb_d = line_act ? i_pixel[1:0] : boot_ctrl_pkg::LSB_RST; // [R18]
        // drivers off in reset, boot and standby, and whenever the enable pin is high
        video_oe_d = streaming && !oe_n_q; // [R5] [R7]
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pclk_q <= 1'b0;
            col_q <= '0;
            row_q <= '0;
            o_pix_data <= boot_ctrl_pkg::PIX_RST;
            o_pix_lsb <= boot_ctrl_pkg::LSB_RST;
            o_pixel_clock_out <= 1'b0;
            o_line_active_short <= 1'b0;
            o_frame_active <= 1'b0;
            o_video_oe <= 1'b0;
            o_twowire_data_pin_oe <= 1'b0;
            o_boot_done <= 1'b0;
            o_in_reset <= 1'b1;
        end else begin
            pclk_q <= pclk_d;
            col_q <= col_d;
            row_q <= row_d;
            o_pix_data <= pix_d;
            o_pix_lsb <= lsb_d;
            o_pixel_clock_out <= pclk_q;
            o_line_active_short <= line_act; // [R14]
            o_frame_active <= streaming && row_q < RW'(ACT_H);
            o_video_oe <= video_oe_d; // [R5]
            // pad only listens while reset is in force
            o_twowire_data_pin_oe <= i_twowire_data_drive && !any_rst
                && state_q != boot_ctrl_pkg::ST_RESET; // [R6]
            o_boot_done <= !any_rst && ((state_q == boot_ctrl_pkg::ST_STREAM)
                || (state_q == boot_ctrl_pkg::ST_STANDBY)); // [R11]
            o_in_reset <= any_rst || state_q == boot_ctrl_pkg::ST_RESET;
        end
    end
endmodule // sensor_reset_boot_control
